// ---- logic/umcb_top.sv ----
// Configuration register bank of a USB optical mouse: keymaps, hold
// timer, tilt scroll, USB identity and string descriptor streaming.
// Assumes a synchronous register master and a host side that pulls
// descriptor bytes with a valid/ready handshake.
// Function
// - Shortcut is one modifier plus one scan code
// - Modifier bits map right/left GUI, Alt, Shift, Ctrl
// - Codes A and B drive keymap outputs
// - Hold time is value times 16 ms; the code takes a value of zero as one 16 ms step
// - Product id is 0xC9:0xC8
// - Vendor id is 0xCB:0xCA
// - Maker length counts length, type, two per char; the stream clips it at 24 bytes, short of the 26 that 12 chars need
// - Maker chars one byte each, 0xCD-0xD8
// - Product length uses same formula, reset 0x34
// - Product chars one byte each, 0xDA-0xF5
// - Device number 0xF7:0xF6, resets zero
// - All-zero use register bypasses the settings
// - Keymaps work only with mode 01 or 10
`timescale 1ns/1ps
module umcb_top #(
  parameter int STEP_CYC = umcb_pkg::HOLD_STEP_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Buttons and tilt wheel
  input wire logic button_held,
  input wire logic keymap_btn_a,
  input wire logic keymap_btn_b,
  input wire logic [1:0] tilt_in,
  output logic long_press_resolution_action,
  output logic [15:0] first_keymap_output,
  output logic [15:0] second_keymap_output,
  output logic [1:0] horiz_scroll,
  // USB identity
  output logic [15:0] product_id,
  output logic [15:0] vendor_id,
  output logic [15:0] device_number_field,
  // String descriptor stream
  input wire logic desc_req,
  input wire logic desc_sel,
  input wire logic desc_ready,
  output logic [7:0] desc_byte,
  output logic desc_valid,
  output logic desc_last
);
  import umcb_pkg::*;

  localparam int SW = $clog2(STEP_CYC + 1);

  typedef struct packed {
    logic [7:0] use_en;
    logic [7:0] dev_mode;
    logic [7:0] mod_a;
    logic [7:0] mod_b;
    logic [7:0] scan_a;
    logic [7:0] scan_b;
    logic [7:0] hold;
    logic [7:0] tilt;
    logic [15:0] pid;
    logic [15:0] vid;
    logic [7:0] mlen;
    logic [7:0] plen;
    logic [15:0] devnum;
    logic [NCHARS-1:0][7:0] chars;
    logic [7:0] lock;
    logic [7:0] rdata;
    logic [SW-1:0] step_cnt;
    logic [7:0] hold_cnt;
    logic lp_done;
    logic lp_pulse;
    logic [15:0] km_a;
    logic [15:0] km_b;
    logic [1:0] hscroll;
    logic [15:0] pid_o;
    logic [15:0] vid_o;
    logic [15:0] dev_o;
    logic busy;
    logic sel;
    logic [5:0] idx;
    logic [5:0] total;
    logic [7:0] dbyte;
    logic dvalid;
    logic dlast;
  } umcb_state_s;

  umcb_state_s s_r;
  umcb_state_s s_nxt;

  // Character slot of a register address; bit 6 flags a hit
  function automatic logic [6:0] char_slot(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a >= ADDR_MCHAR_FIRST && a <= ADDR_MCHAR_LAST) begin
      d = a - ADDR_MCHAR_FIRST;
      char_slot = {1'b1, d[5:0]};
    end else if (a >= ADDR_PCHAR_FIRST && a <= ADDR_PCHAR_LAST) begin
      d = a - ADDR_PCHAR_FIRST + 8'(MCHARS);
      char_slot = {1'b1, d[5:0]};
    end else begin
      char_slot = 7'h00;
    end
  endfunction

  // Byte at position i of a string descriptor
  function automatic logic [7:0] desc_at(input umcb_state_s s, input logic [5:0] i);
    logic [5:0] ci;
    ci = (i - 6'd2) >> 1;
    if (s.sel) begin
      ci = ci + 6'(MCHARS);
    end
    if (i == 6'd0) begin
      desc_at = s.sel ? s.plen : s.mlen;
    end else if (i == 6'd1) begin
      desc_at = STRING_DESC_TYPE;
    end else if (i[0]) begin
      desc_at = 8'h00;
    end else begin
      desc_at = s.chars[ci];
    end
  endfunction

  logic bypass;
  logic km_on;
  logic [6:0] slot;
  logic [5:0] cap;
  logic [7:0] lim;
  logic [7:0] req_len;

  always_comb begin
    s_nxt = s_r;
    bypass = (s_r.use_en == 8'h00);
    km_on = s_r.dev_mode[KM_MODE_HI] ^ s_r.dev_mode[KM_MODE_LO];
    slot = char_slot(reg_addr);
    cap = desc_sel ? PTOTAL_MAX : MTOTAL_MAX;
    req_len = desc_sel ? s_r.plen : s_r.mlen;
    lim = (s_r.hold == 8'h00) ? 8'h01 : s_r.hold;

    // Register writes, frozen once locked
    if (reg_wr && s_r.lock != LOCK_KEY) begin
      if (slot[6]) begin
        s_nxt.chars[slot[5:0]] = reg_wdata;
      end
      case (reg_addr)
        ADDR_USE_ENABLE: s_nxt.use_en = reg_wdata;
        ADDR_DEV_MODE: s_nxt.dev_mode = reg_wdata;
        ADDR_MOD_A: s_nxt.mod_a = reg_wdata;
        ADDR_MOD_B: s_nxt.mod_b = reg_wdata;
        ADDR_SCAN_A: s_nxt.scan_a = reg_wdata;
        ADDR_SCAN_B: s_nxt.scan_b = reg_wdata;
        ADDR_HOLD: s_nxt.hold = reg_wdata;
        ADDR_TILT: s_nxt.tilt = reg_wdata;
        ADDR_PID_LO: s_nxt.pid[7:0] = reg_wdata;
        ADDR_PID_HI: s_nxt.pid[15:8] = reg_wdata;
        ADDR_VID_LO: s_nxt.vid[7:0] = reg_wdata;
        ADDR_VID_HI: s_nxt.vid[15:8] = reg_wdata;
        ADDR_MLEN: s_nxt.mlen = reg_wdata;
        ADDR_PLEN: s_nxt.plen = reg_wdata;
        ADDR_DEVNUM_LO: s_nxt.devnum[7:0] = reg_wdata;
        ADDR_DEVNUM_HI: s_nxt.devnum[15:8] = reg_wdata;
        // Only the key value locks; any other value is stored without locking
        ADDR_LOCK: s_nxt.lock = reg_wdata;
        default: ;
      endcase
    end

    // Register reads, data one cycle later; unmapped reads give zero
    s_nxt.rdata = 8'h00;
    if (reg_rd) begin
      if (slot[6]) begin
        s_nxt.rdata = s_r.chars[slot[5:0]];
      end
      case (reg_addr)
        ADDR_USE_ENABLE: s_nxt.rdata = s_r.use_en;
        ADDR_DEV_MODE: s_nxt.rdata = s_r.dev_mode;
        ADDR_MOD_A: s_nxt.rdata = s_r.mod_a;
        ADDR_MOD_B: s_nxt.rdata = s_r.mod_b;
        ADDR_SCAN_A: s_nxt.rdata = s_r.scan_a;
        ADDR_SCAN_B: s_nxt.rdata = s_r.scan_b;
        ADDR_HOLD: s_nxt.rdata = s_r.hold;
        ADDR_TILT: s_nxt.rdata = s_r.tilt;
        ADDR_PID_LO: s_nxt.rdata = s_r.pid[7:0];
        ADDR_PID_HI: s_nxt.rdata = s_r.pid[15:8];
        ADDR_VID_LO: s_nxt.rdata = s_r.vid[7:0];
        ADDR_VID_HI: s_nxt.rdata = s_r.vid[15:8];
        ADDR_MLEN: s_nxt.rdata = s_r.mlen;
        ADDR_PLEN: s_nxt.rdata = s_r.plen;
        ADDR_DEVNUM_LO: s_nxt.rdata = s_r.devnum[7:0];
        ADDR_DEVNUM_HI: s_nxt.rdata = s_r.devnum[15:8];
        ADDR_LOCK: s_nxt.rdata = s_r.lock;
        ADDR_STATUS: begin
          s_nxt.rdata[ST_LOCKED_BIT] = (s_r.lock == LOCK_KEY);
          s_nxt.rdata[ST_BYPASS_BIT] = bypass;
          s_nxt.rdata[ST_BUSY_BIT] = s_r.busy;
        end
        default: ;
      endcase
    end

    // Keymap outputs carry modifier byte over scan code
    s_nxt.km_a = 16'h0000;
    s_nxt.km_b = 16'h0000;
    if (!bypass && km_on) begin
      if (keymap_btn_a) begin
        s_nxt.km_a = {s_r.mod_a, s_r.scan_a};
      end
      if (keymap_btn_b) begin
        s_nxt.km_b = {s_r.mod_b, s_r.scan_b};
      end
    end

    // Tilt scroll; the bypassed default is enabled
    s_nxt.hscroll = (!bypass && s_r.tilt[TILT_DIS_BIT]) ? 2'b00 : tilt_in;

    // Identity outputs fall back to defaults while bypassed
    s_nxt.pid_o = bypass ? DEF_PID : s_r.pid;
    s_nxt.vid_o = bypass ? DEF_VID : s_r.vid;
    s_nxt.dev_o = bypass ? 16'h0000 : s_r.devnum;

    // Hold timer: counts 16 ms steps, one pulse per press
    if (bypass) begin
      lim = RST_HOLD;
    end
    s_nxt.lp_pulse = 1'b0;
    if (!button_held) begin
      s_nxt.step_cnt = '0;
      s_nxt.hold_cnt = 8'h00;
      s_nxt.lp_done = 1'b0;
    end else if (!s_r.lp_done) begin
      if (s_r.step_cnt == SW'(STEP_CYC - 1)) begin
        s_nxt.step_cnt = '0;
        s_nxt.hold_cnt = s_r.hold_cnt + 8'h01;
        if (s_r.hold_cnt + 8'h01 == lim) begin
          s_nxt.lp_done = 1'b1;
          s_nxt.lp_pulse = 1'b1;
        end
      end else begin
        s_nxt.step_cnt = s_r.step_cnt + SW'(1);
      end
    end

    // String descriptor stream; byte count clipped to 24 bytes for the maker, 58 for the product
    if (!s_r.busy && desc_req) begin
      s_nxt.busy = 1'b1;
      s_nxt.sel = desc_sel;
      s_nxt.idx = 6'd0;
      s_nxt.total = (req_len > 8'(cap)) ? cap : req_len[5:0];
      s_nxt.dbyte = req_len;
      s_nxt.dvalid = 1'b1;
      s_nxt.dlast = (req_len <= 8'h01);
    end else if (s_r.dvalid && desc_ready) begin
      if (s_r.dlast) begin
        s_nxt.busy = 1'b0;
        s_nxt.dvalid = 1'b0;
        s_nxt.dlast = 1'b0;
      end else begin
        s_nxt.idx = s_r.idx + 6'd1;
        s_nxt.dbyte = desc_at(s_r, s_r.idx + 6'd1);
        s_nxt.dlast = (s_r.idx + 6'd2 >= s_r.total);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.hold <= RST_HOLD;
      s_r.mlen <= RST_MLEN;
      s_r.plen <= RST_PLEN;
      s_r.pid_o <= DEF_PID;
      s_r.vid_o <= DEF_VID;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign long_press_resolution_action = s_r.lp_pulse;
  assign first_keymap_output = s_r.km_a;
  assign second_keymap_output = s_r.km_b;
  assign horiz_scroll = s_r.hscroll;
  assign product_id = s_r.pid_o;
  assign vendor_id = s_r.vid_o;
  assign device_number_field = s_r.dev_o;
  assign desc_byte = s_r.dbyte;
  assign desc_valid = s_r.dvalid;
  assign desc_last = s_r.dlast;

  // Checks
  property p_km_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_r.dev_mode[KM_MODE_HI] == s_r.dev_mode[KM_MODE_LO])
      |=> (first_keymap_output == 16'h0000 && second_keymap_output == 16'h0000);
  endproperty
  a_km_off: assert property (p_km_off) else $error("keymap active in disabled mode");

  property p_km_a;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_r.use_en != 8'h00 && (s_r.dev_mode[7] ^ s_r.dev_mode[6]) && keymap_btn_a)
      |=> (first_keymap_output == {$past(s_r.mod_a), $past(s_r.scan_a)});
  endproperty
  a_km_a: assert property (p_km_a) else $error("first keymap code wrong");

  property p_tilt_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_r.use_en != 8'h00 && s_r.tilt[0]) |=> (horiz_scroll == 2'b00);
  endproperty
  a_tilt_off: assert property (p_tilt_off) else $error("tilt scroll not suppressed");

  property p_pid;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_r.use_en != 8'h00) |=> (product_id == $past(s_r.pid) && vendor_id == $past(s_r.vid));
  endproperty
  a_pid: assert property (p_pid) else $error("identity outputs wrong");

  property p_bypass;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_r.use_en == 8'h00) |=> (product_id == DEF_PID && device_number_field == 16'h0000);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not applied");

  property p_locked;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_r.lock == LOCK_KEY && reg_wr) |=> ($stable(s_r.scan_a) && $stable(s_r.devnum) && $stable(s_r.lock));
  endproperty
  a_locked: assert property (p_locked) else $error("write accepted after lock");

  property p_rd_dev;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == ADDR_DEVNUM_HI) |=> (reg_rdata == $past(s_r.devnum[15:8]));
  endproperty
  a_rd_dev: assert property (p_rd_dev) else $error("device number read wrong");

  property p_desc_head;
    @(posedge ref_clk) disable iff (!rst_n)
      (!s_r.busy && desc_req && !desc_sel)
      ##1 (desc_valid && desc_byte == s_r.mlen && desc_ready && !desc_last)
      |=> (desc_valid && desc_byte == STRING_DESC_TYPE);
  endproperty
  a_desc_head: assert property (p_desc_head) else $error("descriptor head order wrong");

  property p_desc_pad;
    @(posedge ref_clk) disable iff (!rst_n)
      (desc_valid && desc_ready && !desc_last && s_r.idx[0] == 1'b0 && s_r.idx != 6'd0)
      |=> (desc_byte == 8'h00);
  endproperty
  a_desc_pad: assert property (p_desc_pad) else $error("character high byte not zero");

  property p_lp_held;
    @(posedge ref_clk) disable iff (!rst_n)
      long_press_resolution_action |-> $past(button_held) ##1 !long_press_resolution_action;
  endproperty
  a_lp_held: assert property (p_lp_held) else $error("hold pulse without press");

  property p_km_b;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_r.use_en != 8'h00 && (s_r.dev_mode[7] ^ s_r.dev_mode[6]) && keymap_btn_b)
      |=> (second_keymap_output == {$past(s_r.mod_b), $past(s_r.scan_b)});
  endproperty
  a_km_b: assert property (p_km_b) else $error("second keymap code wrong");

  property p_devnum;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_r.use_en != 8'h00) |=> (device_number_field == $past(s_r.devnum));
  endproperty
  a_devnum: assert property (p_devnum) else $error("device number output wrong");

  // A stalled host must see the same byte and end flag until it accepts
  property p_desc_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (desc_valid && !desc_ready) |=> (desc_valid && $stable(desc_byte) && $stable(desc_last));
  endproperty
  a_desc_hold: assert property (p_desc_hold) else $error("descriptor byte dropped before accept");
endmodule

// ---- logic/umcb_pkg.sv ----
// Constants of the mouse configuration register bank.
// Register offsets are byte addresses on the plain 8-bit register port.
package umcb_pkg;
  localparam logic [7:0] ADDR_USE_ENABLE = 8'hBB;
  localparam logic [7:0] ADDR_DEV_MODE = 8'hC1;
  localparam logic [7:0] ADDR_MOD_A = 8'hC2;
  localparam logic [7:0] ADDR_MOD_B = 8'hC3;
  localparam logic [7:0] ADDR_SCAN_A = 8'hC4;
  localparam logic [7:0] ADDR_SCAN_B = 8'hC5;
  localparam logic [7:0] ADDR_HOLD = 8'hC6;
  localparam logic [7:0] ADDR_TILT = 8'hC7;
  localparam logic [7:0] ADDR_PID_LO = 8'hC8;
  localparam logic [7:0] ADDR_PID_HI = 8'hC9;
  localparam logic [7:0] ADDR_VID_LO = 8'hCA;
  localparam logic [7:0] ADDR_VID_HI = 8'hCB;
  localparam logic [7:0] ADDR_MLEN = 8'hCC;
  localparam logic [7:0] ADDR_MCHAR_FIRST = 8'hCD;
  localparam logic [7:0] ADDR_MCHAR_LAST = 8'hD8;
  localparam logic [7:0] ADDR_PLEN = 8'hD9;
  localparam logic [7:0] ADDR_PCHAR_FIRST = 8'hDA;
  localparam logic [7:0] ADDR_PCHAR_LAST = 8'hF5;
  localparam logic [7:0] ADDR_DEVNUM_LO = 8'hF6;
  localparam logic [7:0] ADDR_DEVNUM_HI = 8'hF7;
  localparam logic [7:0] ADDR_LOCK = 8'hF8;
  localparam logic [7:0] ADDR_STATUS = 8'hF9;
  // Field positions
  localparam int KM_MODE_HI = 7;
  localparam int KM_MODE_LO = 6;
  localparam int TILT_DIS_BIT = 0;
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_BYPASS_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'h10;
  localparam logic [7:0] RST_MLEN = 8'h0C;
  localparam logic [7:0] RST_PLEN = 8'h34;
  // Identity codes used while bypassed: arbitrary neutral values
  localparam logic [15:0] DEF_PID = 16'h1234;
  localparam logic [15:0] DEF_VID = 16'h5A5A;
  // Values with a meaning
  localparam logic [7:0] LOCK_KEY = 8'hFF;
  localparam logic [7:0] STRING_DESC_TYPE = 8'h03;
  localparam int MCHARS = 12;
  localparam int PCHARS = 28;
  localparam int NCHARS = MCHARS + PCHARS;
  localparam logic [5:0] MTOTAL_MAX = 6'd24;
  localparam logic [5:0] PTOTAL_MAX = 6'd58;
  // Timing: one hold step, in milliseconds and in cycles at 200 MHz
  localparam int CLK_KHZ = 200000;
  localparam int HOLD_STEP_MS = 16;
  localparam int HOLD_STEP_CYC = HOLD_STEP_MS * CLK_KHZ;
endpackage

// ---- testbench/umcb_host_model.sv ----
// Host side of the string descriptor stream: accepts bytes and keeps them.
// Assumes the bank holds each byte until accepted; slow mode stalls every other cycle.
`timescale 1ns/1ps
module umcb_host_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Descriptor stream
  input wire logic [7:0] desc_byte,
  input wire logic desc_valid,
  input wire logic desc_last,
  input wire logic slow,
  output logic desc_ready
);
  logic [7:0] got[$];
  logic tick_r;
  int last_at;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= ~tick_r;
    end
  end
  // Stalls make the bank hold a byte across two cycles
  assign desc_ready = slow ? tick_r : 1'b1;
  always @(posedge ref_clk) begin
    if (desc_valid && desc_ready) begin
      if (desc_last) begin
        last_at = got.size();
      end
      got.push_back(desc_byte);
    end
  end
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the mouse configuration bank.
// Assumes the descriptor host model beside it and a 200 MHz ref_clk.
`timescale 1ns/1ps
module tb;
  import umcb_pkg::*;
  logic ref_clk, rst_n, reg_wr, reg_rd, button_held, keymap_btn_a, keymap_btn_b;
  logic desc_req, desc_sel, desc_ready, desc_valid, desc_last, slow, long_press_resolution_action;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, desc_byte;
  logic [1:0] tilt_in, horiz_scroll;
  logic [15:0] first_keymap_output, second_keymap_output, product_id, vendor_id, device_number_field;
  int err_total, compares;
  umcb_top #(.STEP_CYC(4)) umcb_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .button_held(button_held), .keymap_btn_a(keymap_btn_a), .keymap_btn_b(keymap_btn_b),
    .tilt_in(tilt_in), .long_press_resolution_action(long_press_resolution_action),
    .first_keymap_output(first_keymap_output), .second_keymap_output(second_keymap_output),
    .horiz_scroll(horiz_scroll), .product_id(product_id), .vendor_id(vendor_id),
    .device_number_field(device_number_field), .desc_req(desc_req), .desc_sel(desc_sel),
    .desc_ready(desc_ready), .desc_byte(desc_byte), .desc_valid(desc_valid), .desc_last(desc_last));
  umcb_host_model umcb_host_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .desc_byte(desc_byte),
    .desc_valid(desc_valid), .desc_last(desc_last), .slow(slow), .desc_ready(desc_ready));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic look();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize();
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset();
    logic [7:0] a[11] = '{ADDR_MOD_A, ADDR_MOD_B, ADDR_SCAN_A, ADDR_SCAN_B, ADDR_HOLD, ADDR_TILT,
      ADDR_MLEN, ADDR_PLEN, ADDR_DEVNUM_LO, ADDR_DEVNUM_HI, 8'h10};
    logic [7:0] e[11] = '{8'h00, 8'h00, 8'h00, 8'h00, RST_HOLD, 8'h00, RST_MLEN, RST_PLEN, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 11; i++) begin
      rd(a[i], e[i]);
    end
    @(posedge ref_clk);
    keymap_btn_a <= 1'b1;
    look();
    chk(first_keymap_output, 16'h0000);
    chk(product_id, DEF_PID);
    chk(vendor_id, DEF_VID);
    chk(device_number_field, 16'h0000);
  endtask
  task automatic t_keymap();
    wr(ADDR_USE_ENABLE, 8'hFF);
    wr(ADDR_MOD_A, 8'h40);
    wr(ADDR_SCAN_A, 8'h2B);
    wr(ADDR_MOD_B, 8'h05);
    wr(ADDR_SCAN_B, 8'h4C);
    keymap_btn_b <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_DEV_MODE, {m[1:0], 6'h00});
      look();
      chk(first_keymap_output, (m == 1 || m == 2) ? 16'h402B : 16'h0000);
      chk(second_keymap_output, (m == 1 || m == 2) ? 16'h054C : 16'h0000);
    end
  endtask
  task automatic t_tilt();
    @(posedge ref_clk);
    tilt_in <= 2'b10;
    look();
    chk({14'h0, horiz_scroll}, 16'h0002);
    wr(ADDR_TILT, 8'h01);
    look();
    chk({14'h0, horiz_scroll}, 16'h0000);
  endtask
  task automatic t_ident();
    wr(ADDR_PID_LO, 8'h34);
    wr(ADDR_PID_HI, 8'hA1);
    wr(ADDR_VID_LO, 8'hC3);
    wr(ADDR_VID_HI, 8'h2E);
    wr(ADDR_DEVNUM_LO, 8'h01);
    wr(ADDR_DEVNUM_HI, 8'h80);
    look();
    chk(product_id, 16'hA134);
    chk(vendor_id, 16'h2EC3);
    chk(device_number_field, 16'h8001);
  endtask
  task automatic t_desc(input logic sel, input logic [7:0] len, input logic [23:0] chs, input logic slw);
    logic [7:0] e;
    umcb_host_model_inst.got.delete();
    umcb_host_model_inst.last_at = -1;
    @(posedge ref_clk);
    slow <= slw;
    desc_sel <= sel;
    desc_req <= 1'b1;
    @(posedge ref_clk);
    desc_req <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk(16'(umcb_host_model_inst.got.size()), {8'h00, len});
    for (int i = 0; i < len && i < umcb_host_model_inst.got.size(); i++) begin
      e = (i == 0) ? len : (i == 1) ? STRING_DESC_TYPE : i[0] ? 8'h00 : chs[8 * ((i - 2) / 2) +: 8];
      chk({8'h00, umcb_host_model_inst.got[i]}, {8'h00, e});
    end
    chk(16'(umcb_host_model_inst.last_at), {8'h00, len - 8'h01});
  endtask
  task automatic t_hold();
    int n;
    wr(ADDR_HOLD, 8'h02);
    button_held <= 1'b1;
    n = 0;
    while (long_press_resolution_action !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(16'(n), 16'h0008);
    n = 0;
    repeat (30) begin
      @(posedge ref_clk);
      #1;
      n += (long_press_resolution_action === 1'b1);
    end
    chk(16'(n), 16'h0000);
    button_held <= 1'b0;
  endtask
  initial begin
    err_total = 0;
    compares = 0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, button_held, keymap_btn_a, keymap_btn_b, desc_req, desc_sel, slow} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    tilt_in = 2'b00;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_keymap();
    t_tilt();
    t_ident();
    wr(ADDR_MLEN, 8'h06);
    wr(ADDR_MCHAR_FIRST, 8'h48);
    wr(ADDR_MCHAR_FIRST + 8'h01, 8'h69);
    t_desc(1'b0, 8'h06, 24'h006948, 1'b1);
    wr(ADDR_PLEN, 8'h08);
    wr(ADDR_PCHAR_FIRST, 8'h61);
    wr(ADDR_PCHAR_FIRST + 8'h01, 8'h62);
    wr(ADDR_PCHAR_FIRST + 8'h02, 8'h63);
    t_desc(1'b1, 8'h08, 24'h636261, 1'b0);
    t_hold();
    // Locking must freeze every later write
    wr(ADDR_LOCK, LOCK_KEY);
    wr(ADDR_MOD_A, 8'h11);
    rd(ADDR_MOD_A, 8'h40);
    rd(ADDR_STATUS, 8'h01);
    summarize();
  end
  initial begin
    #100000;
    err_total++;
    summarize();
  end
endmodule
